// ---- rtl/tcio_top.sv ----
/*
 * Pin function control for general registers C and D of timer channel 0:
 * output compare with initial level and match action, or input capture
 * on pin edges or channel 1 count events, with buffer-mode interlocks.
 * Assumes pins and counter events synchronous to clk; the channel 0
 * counter and channel 1 counter live outside this block.
 */
// How it works
// - Bits 7 to 4 of the I/O control register steer register D and its pin, bits 3 to 0 steer register C.
// - A field with top bit 0 is output compare, and low bits 00 keep the pin undriven.
// - In compare mode the field's bit 2 gives the initial pin level, 0 low and 1 high.
// - Low bits 01 drive the pin low at each compare match.
// - Low bits 10 drive the pin high at each compare match.
// - Low bits 11 invert the pin at each compare match.
// - Field 1000 captures the counter on a rising pin edge.
// - Field 1001 captures the counter on a falling pin edge.
// - Field 101x captures the counter on both pin edges.
// - Field 11xx captures the counter on each channel 1 count up or down.
// - Register D's channel 1 capture never fires while the ch1 prescaler is 000.
// - With buffer-B mode set, register D neither captures nor drives compare output.
// - With buffer-A mode set, register C neither captures nor drives compare output.
`timescale 1ns/1ns
module tcio_top #(
    parameter int CW = tcio_pkg::TCIO_CW
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic [4:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic      [31:0]   avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [CW-1:0] ch0_count,
    input  wire logic          ch0_count_tick,
    input  wire logic          ch1_count_up,
    input  wire logic          ch1_count_down,
    input  wire logic          ch0_pin_c_in,
    output logic               ch0_pin_c_out,
    output logic               ch0_pin_c_oe_n,
    input  wire logic          ch0_pin_d_in,
    output logic               ch0_pin_d_out,
    output logic               ch0_pin_d_oe_n,
    output logic               capture_c,
    output logic               capture_d
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (CW != tcio_pkg::TCIO_CW)
    begin : g_bad_cw
        $error("CW must equal the package counter width");
    end

    // ------------------------------------------------------------------
    // State and per-register pin function
    // ------------------------------------------------------------------
    tcio_pkg::tcio_state_s st;
    tcio_pkg::tcio_state_s next_st;

    // One register's capture trigger and pin drive for this cycle
    function automatic tcio_pkg::tcio_ch_s ch_eval(
        input logic [3:0] fld,
        input logic       buf_md,
        input logic       pin,
        input logic       prev,
        input logic       match,
        input logic       ch1_evt,
        input logic       ch1_ok,
        input logic       lvl,
        input logic       wr_init
    );
        tcio_pkg::tcio_ch_s r;
        r.cap  = 1'b0;
        r.lvl  = lvl;
        r.oe_n = 1'b1;
        if (buf_md)
        begin
            r.oe_n = 1'b1;
        end
        else if (!fld[3])
        begin
            r.oe_n = (fld[1:0] == 2'h0);
            if (wr_init)
            begin
                r.lvl = fld[2];
            end
            else if (match)
            begin
                unique case (fld[1:0])
                    2'h1:    r.lvl = 1'b0;
                    2'h2:    r.lvl = 1'b1;
                    2'h3:    r.lvl = ~lvl;
                    default: r.lvl = lvl;
                endcase
            end
        end
        else if (fld[2])
        begin
            r.cap = ch1_evt & ch1_ok;
        end
        else if (fld[1])
        begin
            r.cap = pin ^ prev;
        end
        else if (fld[0])
        begin
            r.cap = prev & ~pin;
        end
        else
        begin
            r.cap = ~prev & pin;
        end
        return r;
    endfunction : ch_eval

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic               req;
    logic               wr_take;
    logic               io_wr;
    logic [3:0]         fld_c;
    logic [3:0]         fld_d;
    logic [1:0]         pin_now;
    logic               ch1_evt;
    tcio_pkg::tcio_ch_s res_c;
    tcio_pkg::tcio_ch_s res_d;

    // Request is served when waitrequest is low at the edge
    assign req     = avs_read | avs_write;
    assign wr_take = avs_write & ~st.waitreq;
    assign io_wr   = wr_take & avs_byteenable[0]
                   & (avs_address == tcio_pkg::TCIO_OFS_IOCTL);
    assign pin_now = {ch0_pin_d_in, ch0_pin_c_in};
    assign ch1_evt = ch1_count_up | ch1_count_down;

    // Fields in force: a new setting takes effect with its write
    assign fld_d = io_wr ? avs_writedata[7:4]
                         : st.ioctl[tcio_pkg::TCIO_FLD_D_LSB +: 4];
    assign fld_c = io_wr ? avs_writedata[3:0]
                         : st.ioctl[tcio_pkg::TCIO_FLD_C_LSB +: 4];

    // Evaluate both registers
    always_comb
    begin
        res_c = ch_eval(fld_c, st.buf_a, pin_now[tcio_pkg::TCIO_CH_C],
                        st.prev[tcio_pkg::TCIO_CH_C],
                        ch0_count_tick && (ch0_count == st.greg_c),
                        ch1_evt, 1'b1, st.lvl[tcio_pkg::TCIO_CH_C], io_wr);
        res_d = ch_eval(fld_d, st.buf_b, pin_now[tcio_pkg::TCIO_CH_D],
                        st.prev[tcio_pkg::TCIO_CH_D],
                        ch0_count_tick && (ch0_count == st.greg_d),
                        ch1_evt, st.psc != tcio_pkg::TCIO_PSC_UNDIV,
                        st.lvl[tcio_pkg::TCIO_CH_D], io_wr);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_st.waitreq = 1'b1;
        next_st.prev    = pin_now;
        // Answer one cycle after a request appears
        if (req && st.waitreq)
        begin
            next_st.waitreq = 1'b0;
            unique case (avs_address)
                tcio_pkg::TCIO_OFS_IOCTL:   next_st.rdata = {24'h0, st.ioctl};
                tcio_pkg::TCIO_OFS_MODE:    next_st.rdata =
                    {30'h0, st.buf_b, st.buf_a};
                tcio_pkg::TCIO_OFS_CH1:     next_st.rdata = {29'h0, st.psc};
                tcio_pkg::TCIO_OFS_GREG_C:  next_st.rdata = {16'h0, st.greg_c};
                tcio_pkg::TCIO_OFS_GREG_D:  next_st.rdata = {16'h0, st.greg_d};
                tcio_pkg::TCIO_OFS_STAT:    next_st.rdata =
                    {26'h0, st.cap, st.oe_n, st.lvl};
                default:                    next_st.rdata = 32'h0;
            endcase
        end
        // Register writes on the accepting edge
        if (wr_take)
        begin
            unique case (avs_address)
                tcio_pkg::TCIO_OFS_IOCTL:
                begin
                    if (avs_byteenable[0]) next_st.ioctl = avs_writedata[7:0];
                end
                tcio_pkg::TCIO_OFS_MODE:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_st.buf_a = avs_writedata[tcio_pkg::TCIO_BIT_BUF_A];
                        next_st.buf_b = avs_writedata[tcio_pkg::TCIO_BIT_BUF_B];
                    end
                end
                tcio_pkg::TCIO_OFS_CH1:
                begin
                    if (avs_byteenable[0]) next_st.psc = avs_writedata[2:0];
                end
                tcio_pkg::TCIO_OFS_GREG_C:
                begin
                    if (avs_byteenable[0]) next_st.greg_c[7:0]  =
                        avs_writedata[7:0];
                    if (avs_byteenable[1]) next_st.greg_c[15:8] =
                        avs_writedata[15:8];
                end
                tcio_pkg::TCIO_OFS_GREG_D:
                begin
                    if (avs_byteenable[0]) next_st.greg_d[7:0]  =
                        avs_writedata[7:0];
                    if (avs_byteenable[1]) next_st.greg_d[15:8] =
                        avs_writedata[15:8];
                end
                default: ;
            endcase
        end
        // Pin drive and capture; a capture beats a same-cycle bus write
        next_st.lvl  = {res_d.lvl, res_c.lvl};
        next_st.oe_n = {res_d.oe_n, res_c.oe_n};
        next_st.cap  = {res_d.cap, res_c.cap};
        if (res_c.cap)
        begin
            next_st.greg_c = ch0_count;
        end
        if (res_d.cap)
        begin
            next_st.greg_d = ch0_count;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st         <= '0;
            st.ioctl   <= tcio_pkg::TCIO_RST_IOCTL;
            st.psc     <= tcio_pkg::TCIO_RST_PSC;
            st.oe_n    <= 2'h3;
            st.waitreq <= 1'b1;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign ch0_pin_c_out   = st.lvl[tcio_pkg::TCIO_CH_C];
    assign ch0_pin_c_oe_n  = st.oe_n[tcio_pkg::TCIO_CH_C];
    assign ch0_pin_d_out   = st.lvl[tcio_pkg::TCIO_CH_D];
    assign ch0_pin_d_oe_n  = st.oe_n[tcio_pkg::TCIO_CH_D];
    assign capture_c       = st.cap[tcio_pkg::TCIO_CH_C];
    assign capture_d       = st.cap[tcio_pkg::TCIO_CH_D];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic cmp_c;
    logic live_c;
    logic match_c;
    logic rise_d;
    logic fall_d;
    assign cmp_c   = !fld_c[3] && !st.buf_a && !io_wr;
    assign live_c  = !st.buf_a && !io_wr;
    assign match_c = ch0_count_tick && (ch0_count == st.greg_c);
    assign rise_d  = !st.prev[tcio_pkg::TCIO_CH_D] && ch0_pin_d_in;
    assign fall_d  = st.prev[tcio_pkg::TCIO_CH_D] && !ch0_pin_d_in;

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence s_cap_d;
        capture_d && (ch0_pin_d_oe_n == 1'b1);
    endsequence

    bus_answer_a: assert property (
        (ce && req && avs_waitrequest) |=> s_answer)
        else $error("waitrequest did not drop for one cycle");

    init_level_a: assert property (
        (ce && io_wr && !avs_writedata[3] && !st.buf_a
         && avs_writedata[1:0] != 2'h0)
        |=> (ch0_pin_c_out == $past(avs_writedata[2])) && !ch0_pin_c_oe_n)
        else $error("initial level not applied on write");

    init_d_a: assert property (
        (ce && io_wr && !avs_writedata[7] && !st.buf_b)
        |=> ch0_pin_d_out == $past(avs_writedata[6]))
        else $error("register D initial level wrong");

    oe_off_a: assert property (
        (ce && cmp_c && fld_c[1:0] == 2'h0) |=> ch0_pin_c_oe_n)
        else $error("pin driven with output disabled");

    match_low_a: assert property (
        (ce && cmp_c && match_c && fld_c[1:0] == 2'h1) |=> !ch0_pin_c_out)
        else $error("match did not drive low");

    match_high_a: assert property (
        (ce && cmp_c && match_c && fld_c[1:0] == 2'h2) |=> ch0_pin_c_out)
        else $error("match did not drive high");

    match_toggle_a: assert property (
        (ce && cmp_c && match_c && fld_c[1:0] == 2'h3)
        |=> ch0_pin_c_out != $past(ch0_pin_c_out))
        else $error("match did not toggle");

    rise_cap_a: assert property (
        (ce && live_c && fld_c == 4'h8 && !st.prev[0] && ch0_pin_c_in)
        |=> capture_c && st.greg_c == $past(ch0_count))
        else $error("rising edge not captured");

    fall_cap_a: assert property (
        (ce && !st.buf_b && !io_wr && fld_d == 4'h9)
        |=> capture_d == $past(fall_d))
        else $error("falling edge capture wrong");

    both_cap_a: assert property (
        (ce && !st.buf_b && !io_wr && fld_d[3:1] == 3'h5
         && (rise_d || fall_d)) |=> s_cap_d)
        else $error("edge not captured in both-edge mode");

    ch1_cap_a: assert property (
        (ce && live_c && fld_c[3:2] == 2'h3)
        |=> capture_c == $past(ch1_evt))
        else $error("channel 1 capture wrong");

    psc_block_a: assert property (
        (ce && fld_d[3:2] == 2'h3 && st.psc == tcio_pkg::TCIO_PSC_UNDIV)
        |=> !capture_d)
        else $error("capture with undivided channel 1 clock");

    buf_d_a: assert property (
        (ce && st.buf_b) |=> !capture_d && ch0_pin_d_oe_n)
        else $error("register D active in buffer mode");

    buf_c_a: assert property (
        (ce && st.buf_a) |=> !capture_c && ch0_pin_c_oe_n)
        else $error("register C active in buffer mode");

endmodule : tcio_top

// ---- rtl/tcio_pkg.sv ----
/*
 * Shared constants and types for the channel 0 register C/D I/O control
 * block: register map, field positions, reset values and state layout.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package tcio_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] TCIO_OFS_IOCTL  = 5'h00; // ch0_io_control_low
    localparam logic [4:0] TCIO_OFS_MODE   = 5'h04; // ch0_mode_reg bits
    localparam logic [4:0] TCIO_OFS_CH1    = 5'h08; // ch1_control_reg bits
    localparam logic [4:0] TCIO_OFS_GREG_C = 5'h0c; // ch0_general_reg_c
    localparam logic [4:0] TCIO_OFS_GREG_D = 5'h10; // ch0_general_reg_d
    localparam logic [4:0] TCIO_OFS_STAT   = 5'h14; // pin state, read only

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TCIO_FLD_D_LSB   = 4;  // regd_func_bit3..0
    localparam int TCIO_FLD_C_LSB   = 0;  // regc_func_bit3..0
    localparam int TCIO_BIT_BUF_A   = 0;  // buffer_a_mode_bit
    localparam int TCIO_BIT_BUF_B   = 1;  // buffer_b_mode_bit
    localparam int TCIO_CH_C        = 0;  // Index of register C
    localparam int TCIO_CH_D        = 1;  // Index of register D

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int         TCIO_CW         = 16;
    localparam logic [7:0] TCIO_RST_IOCTL  = 8'h00;
    localparam logic [2:0] TCIO_RST_PSC    = 3'h0;
    localparam logic [2:0] TCIO_PSC_UNDIV  = 3'h0; // Undivided ch1 clock

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Result of evaluating one register's pin function for a cycle
    typedef struct packed {
        logic cap;
        logic lvl;
        logic oe_n;
    } tcio_ch_s;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]         ioctl;
        logic               buf_a;
        logic               buf_b;
        logic [2:0]         psc;
        logic [TCIO_CW-1:0] greg_c;
        logic [TCIO_CW-1:0] greg_d;
        logic [1:0]         lvl;
        logic [1:0]         oe_n;
        logic [1:0]         prev;
        logic [1:0]         cap;
        logic               waitreq;
        logic [31:0]        rdata;
    } tcio_state_s;

endpackage : tcio_pkg

// ---- verification/tcio_far.sv ----
/*
 * Far-side model: outside levels of the two timer pins and the count
 * pulses of the channel 1 counter.
 * Assumes its tasks are called by the bench just after a rising edge.
 */
`timescale 1ns/1ns
module tcio_far (
    input  wire logic clk,
    input  wire logic pin_c_out,
    input  wire logic pin_c_oe_n,
    input  wire logic pin_d_out,
    input  wire logic pin_d_oe_n,
    output logic      pin_c_in,
    output logic      pin_d_in,
    output logic      ch1_up,
    output logic      ch1_down
);
    logic [1:0] ext = 2'h0;

    // Wire level: the device wins while it drives, else the outside level
    assign pin_c_in = pin_c_oe_n ? ext[0] : pin_c_out;
    assign pin_d_in = pin_d_oe_n ? ext[1] : pin_d_out;

    // Count pulses idle low
    initial
    begin
        ch1_up   = 1'b0;
        ch1_down = 1'b0;
    end

    // Sets the outside level of both pins, bit 1 for D
    task set_pins(input logic [1:0] v);
        ext <= v;
    endtask : set_pins

    // One count event of the channel 1 counter, one clock long
    task count_ch1(input logic dn);
        @(posedge clk);
        ch1_up   <= !dn;
        ch1_down <= dn;
        @(posedge clk);
        ch1_up   <= 1'b0;
        ch1_down <= 1'b0;
    endtask : count_ch1
endmodule : tcio_far

// ---- verification/timer_ch0_cd_io_control_tb.sv ----
/*
 * Self-checking bench for the register C/D pin function block.
 * Assumes tcio_pkg, tcio_top and tcio_far are compiled before it.
 */
`timescale 1ns/1ns
module timer_ch0_cd_io_control_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] ch0_count;
    logic        ce;
    logic [3:0]  avs_byteenable, lanes;
    logic        ch0_count_tick, up, down, cap_c, cap_d;
    logic        pc_in, pc_out, pc_oe_n, pd_in, pd_out, pd_oe_n;
    int          errors = 0;
    int          n_tests = 0;
    int          seed = 32'h1583;
    int          ncap_c, ncap_d, f, k, e, m, g, lv, lc, ps;

    // ------------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------------
    tcio_top u_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ch0_count(ch0_count),
        .ch0_count_tick(ch0_count_tick), .ch1_count_up(up),
        .ch1_count_down(down), .ch0_pin_c_in(pc_in),
        .ch0_pin_c_out(pc_out), .ch0_pin_c_oe_n(pc_oe_n),
        .ch0_pin_d_in(pd_in), .ch0_pin_d_out(pd_out),
        .ch0_pin_d_oe_n(pd_oe_n), .capture_c(cap_c), .capture_d(cap_d));
    tcio_far u_far (.clk(clk), .pin_c_out(pc_out), .pin_c_oe_n(pc_oe_n),
        .pin_d_out(pd_out), .pin_d_oe_n(pd_oe_n), .pin_c_in(pc_in),
        .pin_d_in(pd_in), .ch1_up(up), .ch1_down(down));

    // ------------------------------------------------------------------
    // Tasks and model
    // ------------------------------------------------------------------
    task complete_run;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_byteenable <= lanes;
        avs_write     <= w;
        avs_read      <= !w;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20)
        begin
            errors++;
            complete_run();
        end
    endtask : bus

    task rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check("readdata", q, exp);
    endtask : rdchk

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // One counter tick at a given count value
    task tick_at(input logic [15:0] c);
        @(posedge clk);
        ch0_count      <= c;
        ch0_count_tick <= 1'b1;
        @(posedge clk);
        ch0_count_tick <= 1'b0;
        step(1);
    endtask : tick_at

    task pins(input int ld, input int lc, input int on);
        if (on)
        begin
            check("pin d", pd_out, ld);
            check("pin c", pc_out, lc);
        end
    endtask : pins

    // Pin level after a compare match for a given field
    function int act(input int fld, input int l);
        case (fld % 4)
            1: return 0;
            2: return 1;
            3: return l ^ 1;
            default: return l;
        endcase
    endfunction : act

    // ------------------------------------------------------------------
    // Clock, capture counting, main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Counts capture pulses, one per high cycle
    always @(posedge clk)
    begin
        if (cap_c === 1'b1) ncap_c++;
        if (cap_d === 1'b1) ncap_d++;
    end

    initial
    begin
        rstn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        lanes = 4'hf;
        ce = 1'b1;
        ch0_count = 16'h0;
        ch0_count_tick = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, and an unmapped place that ignores writes
        bus(1'b1, 5'h18, 32'hff);
        for (k = 0; k < 7; k++)
            rdchk(5'(k * 4), k == 5 ? 32'hc : 32'h0);
        // Byte lanes gate writes: lane 0 off leaves the fields alone
        lanes = 4'he;
        bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, 32'h77);
        lanes = 4'h2;
        bus(1'b1, tcio_pkg::TCIO_OFS_GREG_C, 32'h1234);
        lanes = 4'hf;
        rdchk(tcio_pkg::TCIO_OFS_IOCTL, 32'h0);
        rdchk(tcio_pkg::TCIO_OFS_GREG_C, 32'h1200);
        // Compare modes: D gets f, C gets f with bit 2 flipped
        for (f = 0; f < 8; f++)
        begin
            g = {$random(seed)} % 65536;
            bus(1'b1, tcio_pkg::TCIO_OFS_GREG_C, g);
            bus(1'b1, tcio_pkg::TCIO_OFS_GREG_D, g);
            bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, f * 16 + (f ^ 4));
            step(1);
            check("oe_n d", pd_oe_n, f % 4 == 0);
            check("oe_n c", pc_oe_n, f % 4 == 0);
            lv = f / 4;
            lc = lv ^ 1;
            pins(lv, lc, f % 4);
            for (k = 0; k < 3; k++)
            begin
                tick_at(k == 0 ? g + 1 : g);
                lv = k ? act(f, lv) : lv;
                lc = k ? act(f, lc) : lc;
                pins(lv, lc, f % 4);
            end
        end
        // Pin captures on rising then falling edges
        bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, 32'h0);
        for (f = 8; f < 12; f++)
        begin
            bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, f * 17);
            for (e = 0; e < 2; e++)
            begin
                g = {$random(seed)} % 65536;
                step(1);
                ncap_c = 0;
                ncap_d = 0;
                @(posedge clk);
                ch0_count <= g;
                u_far.set_pins(e ? 2'h0 : 2'h3);
                step(3);
                k = e ? f != 8 : f != 9;
                check("cap c", ncap_c, k);
                check("cap d", ncap_d, k);
                if (k) rdchk(tcio_pkg::TCIO_OFS_GREG_C, g);
                if (k) rdchk(tcio_pkg::TCIO_OFS_GREG_D, g);
            end
        end
        // Channel 1 triggered capture, undivided then divided clock
        bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, 32'hcc);
        for (e = 0; e < 2; e++)
        begin
            ps = e ? 1 + {$random(seed)} % 7 : 0;
            bus(1'b1, tcio_pkg::TCIO_OFS_CH1, ps);
            step(1);
            ncap_c = 0;
            ncap_d = 0;
            u_far.count_ch1(1'b0);
            u_far.count_ch1(1'b1);
            step(3);
            check("cap c", ncap_c, 2);
            check("cap d", ncap_d, e * 2);
        end
        // Clock enable low freezes the block: a count event is missed
        ncap_c = 0;
        ncap_d = 0;
        @(posedge clk);
        ce <= 1'b0;
        u_far.count_ch1(1'b0);
        @(posedge clk);
        ce <= 1'b1;
        step(3);
        check("cap frozen", ncap_c + ncap_d, 0);
        // Buffer modes block compare output and capture
        for (m = 1; m < 4; m++)
        begin
            bus(1'b1, tcio_pkg::TCIO_OFS_MODE, m);
            rdchk(tcio_pkg::TCIO_OFS_MODE, m);
            bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, 32'h11);
            step(1);
            check("oe_n c", pc_oe_n, m % 2);
            check("oe_n d", pd_oe_n, m / 2);
            bus(1'b1, tcio_pkg::TCIO_OFS_IOCTL, 32'haa);
            step(1);
            ncap_c = 0;
            ncap_d = 0;
            @(posedge clk);
            u_far.set_pins(2'h3);
            step(3);
            check("cap c", ncap_c, 1 - m % 2);
            check("cap d", ncap_d, 1 - m / 2);
            @(posedge clk);
            u_far.set_pins(2'h0);
            step(3);
        end
        complete_run();
    end
endmodule : timer_ch0_cd_io_control_tb
